// ==== bench/spc_checker.sv ====
/* Assertions on the spc_top pins.
   Assumes the bind hands over the shortened counts. */
module spc_checker #(
  parameter integer CTRL_DEB = 20,
  parameter integer LOCK_CYC = 40
) (
  input wire clk,
  input wire rst_n,
  input wire run_req_n,
  input wire supply_ready,
  input wire out_of_spec,
  input wire main_on,
  input wire aux_on,
  input wire system_hold_n_oe,
  input wire fault_n_oe,
  input wire i2c0_scl_i,
  input wire i2c0_sda_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  integer lo_n;
  integer hi_n;
  integer gap;
  reg req_lo;
  // Pin-side filter model; late release covers the sync delay
  always @(posedge clk) begin
    if (!rst_n) begin
      lo_n <= 0;
      hi_n <= 0;
      req_lo <= 1'b0;
      gap <= LOCK_CYC;
    end else begin
      lo_n <= run_req_n ? 0 : (lo_n < CTRL_DEB ? lo_n + 1 : lo_n);
      hi_n <= !run_req_n ? 0 : (hi_n < CTRL_DEB + 4 ? hi_n + 1 : hi_n);
      if (lo_n == CTRL_DEB) req_lo <= 1'b1;
      else if (hi_n == CTRL_DEB + 4) req_lo <= 1'b0;
      if ($rose(main_on) || $rose(aux_on)) gap <= 1;
      else if (gap < LOCK_CYC) gap <= gap + 1;
    end
  end
  sequence s_bad;
    (!system_hold_n_oe && out_of_spec) [*6];
  endsequence
  sequence s_good;
    (!system_hold_n_oe && !out_of_spec) [*6];
  endsequence
  a_on_debounced: assert property (($rose(main_on) || $rose(aux_on)) |-> req_lo)
    else $error("rail on without settled request");
  a_on_lockout: assert property (($rose(main_on) || $rose(aux_on)) |-> gap >= LOCK_CYC)
    else $error("rail on inside lockout");
  a_main_aux: assert property (main_on |-> aux_on)
    else $error("main on with aux off");
  a_hold_off: assert property (system_hold_n_oe |-> !main_on && !aux_on)
    else $error("rail on during hold");
  a_hold_ready: assert property ($fell(system_hold_n_oe) |-> $past(supply_ready, 4))
    else $error("hold released before ready");
  a_fault_set: assert property (s_bad |-> fault_n_oe)
    else $error("fault line not pulled");
  a_fault_clear: assert property (s_good |-> !fault_n_oe)
    else $error("fault line stuck");
  a_sda_scl_low: assert property ($changed(i2c0_sda_oe) |-> !i2c0_scl_i)
    else $error("data changed with clock high");
endmodule // spc_checker
bind spc_top spc_checker #(.CTRL_DEB(CTRL_DEB), .LOCK_CYC(LOCK_CYC)) chk_u (
  .clk(clk), .rst_n(rst_n), .run_req_n(run_req_n), .supply_ready(supply_ready),
  .out_of_spec(out_of_spec), .main_on(main_on), .aux_on(aux_on),
  .system_hold_n_oe(system_hold_n_oe), .fault_n_oe(fault_n_oe),
  .i2c0_scl_i(i2c0_scl_i), .i2c0_sda_oe(i2c0_sda_oe));

// ==== bench/spc_mgr.sv ====
/* Backplane manager model: one I2C master on a wired-and bus.
   Assumes pull-ups on both lines and a target that never stretches. */
module spc_mgr (
  input wire logic clk,
  input wire logic scl_oe,
  input wire logic sda_oe,
  output wire logic scl,
  output wire logic sda,
  output logic rd_stb,
  output logic [7:0] rd_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_dn = 1'b0;
  logic sda_dn = 1'b0;
  // Released lines rise through the pull-ups, never hold a stale level
  assign scl = !(scl_dn || scl_oe);
  assign sda = !(sda_dn || sda_oe);
  initial rd_stb = 1'b0;
  initial rd_byte = 8'h00;
  task automatic hp();
    repeat (10) @(negedge clk);
  endtask
  task automatic put(input logic b);
    sda_dn = !b;
    hp();
    scl_dn = 1'b0;
    hp();
    scl_dn = 1'b1;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put(b[i]);
    sda_dn = 1'b0;
    hp();
    scl_dn = 1'b0;
    hp();
    ack = !sda;
    scl_dn = 1'b1;
  endtask
  task automatic take(input logic last);
    logic [7:0] b;
    sda_dn = 1'b0;
    for (int i = 0; i < 8; i++) begin
      hp();
      scl_dn = 1'b0;
      hp();
      b = {b[6:0], sda};
      scl_dn = 1'b1;
    end
    rd_byte = b;
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    put(last);
  endtask
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, input integer k, output logic ok);
    logic k1, k2, k3;
    sda_dn = 1'b1;
    hp();
    scl_dn = 1'b1;
    send({a, 1'b0}, k1);
    k2 = 1'b0;
    k3 = 1'b0;
    if (k1) send(c, k2);
    if (k2) begin
      sda_dn = 1'b0;
      hp();
      scl_dn = 1'b0;
      hp();
      sda_dn = 1'b1;
      hp();
      scl_dn = 1'b1;
      send({a, 1'b1}, k3);
    end
    if (k3) for (int i = 1; i <= k; i++) take(i == k);
    sda_dn = 1'b1;
    hp();
    scl_dn = 1'b0;
    hp();
    sda_dn = 1'b0;
    hp();
    ok = k1 && k2 && k3;
  endtask
endmodule // spc_mgr

// ==== bench/supply_control_pin_logic_bench.sv ====
/* Self-checking bench for spc_top, one manager model per port.
   Assumes shortened debounce and lockout counts. */
module supply_control_pin_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer DEB = 20;
  localparam integer LCK = 200;
  logic clk = 1'b0, rst_n = 1'b0, run_n = 1'b1, hoff_n = 1'b1;
  logic id0_n = 1'b1, id1_n = 1'b1, rdy = 1'b0, oos = 1'b0, ok;
  logic [7:0] ta = 8'h00, tb = 8'h00;
  logic [7:0] exp_q[$];
  integer fail_count = 0, checks = 0, cyc = 0, n;
  wire main_on, aux_on, hold_oe, flt_oe, stb0, stb1;
  wire scl0, sda0, scl1, sda1, scl0_oe, sda0_oe, scl1_oe, sda1_oe;
  wire [7:0] rb0, rb1;
  wire [5:0] lvl;
  always #2 clk = ~clk;
  spc_top #(.CTRL_DEB(DEB), .ADDR_DEB(DEB), .LOCK_CYC(LCK)) dut_u (
    .clk(clk), .rst_n(rst_n), .run_req_n(run_n), .hold_off_n(hoff_n),
    .slot_id_bit0_n(id0_n), .slot_id_bit1_n(id1_n), .supply_ready(rdy),
    .out_of_spec(oos), .temp_a(ta), .temp_b(tb), .main_on(main_on), .aux_on(aux_on),
    .system_hold_n_i(!hold_oe), .system_hold_n_o(lvl[0]), .system_hold_n_oe(hold_oe),
    .fault_n_i(!flt_oe), .fault_n_o(lvl[1]), .fault_n_oe(flt_oe),
    .i2c0_scl_i(scl0), .i2c0_scl_o(lvl[2]), .i2c0_scl_oe(scl0_oe),
    .i2c0_sda_i(sda0), .i2c0_sda_o(lvl[3]), .i2c0_sda_oe(sda0_oe),
    .i2c1_scl_i(scl1), .i2c1_scl_o(lvl[4]), .i2c1_scl_oe(scl1_oe),
    .i2c1_sda_i(sda1), .i2c1_sda_o(lvl[5]), .i2c1_sda_oe(sda1_oe));
  spc_mgr m0 (.clk(clk), .scl_oe(scl0_oe), .sda_oe(sda0_oe), .scl(scl0), .sda(sda0),
    .rd_stb(stb0), .rd_byte(rb0));
  spc_mgr m1 (.clk(clk), .scl_oe(scl1_oe), .sda_oe(sda1_oe), .scl(scl1), .sda(sda1),
    .rd_stb(stb1), .rd_byte(rb1));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wt(input integer k);
    repeat (k) @(negedge clk);
  endtask
  task automatic rd(input logic p, input logic [6:0] a, input logic [7:0] c, input integer k);
    if (p) m1.xfer(a, c, k, ok);
    else m0.xfer(a, c, k, ok);
  endtask
  task automatic power_up(input logic [1:0] s);
    rst_n = 1'b0;
    rdy = 1'b0;
    {id1_n, id0_n} = ~s;
    wt(10);
    rst_n = 1'b1;
    wt(DEB + 4);
    // A short flip across the capture point must not reach the address
    {id1_n, id0_n} = s;
    wt(6);
    {id1_n, id0_n} = ~s;
    wt(10);
    chk("hold early", hold_oe, 1'b1);
    chk("fault early", flt_oe, 1'b1);
    rdy = 1'b1;
    wt(10);
    chk("hold ready", hold_oe, 1'b0);
    chk("fault ready", flt_oe, 1'b0);
    chk("drive levels", {scl1_oe, scl0_oe, lvl}, 8'h00);
  endtask
  // Oldest note is matched to each byte the managers collect
  always @(posedge clk) begin
    if (stb0 || stb1) begin
      if (exp_q.size() == 0) chk("spare byte", 8'h01, 8'h00);
      else chk("read byte", stb0 ? rb0 : rb1, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    n = $urandom(32'h99740e2d);
    for (int s = 0; s < 4; s++) begin
      power_up(2'(s));
      ta = 8'($urandom);
      tb = 8'($urandom);
      exp_q.push_back(ta > tb ? ta : tb);
      rd(s[0], 7'h20 + 7'(s), 8'h21, 1);
      chk("ack own", ok, 1'b1);
      rd(!s[0], 7'h20 + 7'(s ^ 1), 8'h21, 1);
      chk("ack other", ok, 1'b0);
    end
    $display("address tests done");
    {id1_n, id0_n} = 2'b11;
    wt(DEB + 20);
    exp_q.push_back(ta);
    exp_q.push_back(tb);
    exp_q.push_back(8'hff);
    rd(1'b1, 7'h23, 8'h92, 3);
    chk("ack kept", ok, 1'b1);
    rd(1'b0, 7'h20, 8'h92, 1);
    chk("ack moved", ok, 1'b0);
    oos = 1'b1;
    wt(6);
    chk("fault set", flt_oe, 1'b1);
    oos = 1'b0;
    wt(6);
    chk("fault clear", flt_oe, 1'b0);
    $display("status tests done");
    run_n = 1'b0;
    wt(DEB / 2);
    run_n = 1'b1;
    wt(DEB + 10);
    chk("glitch", main_on, 1'b0);
    run_n = 1'b0;
    n = 0;
    while (main_on !== 1'b1 && n < 100) begin
      wt(1);
      n++;
    end
    chk("all on", {main_on, aux_on}, 2'b11);
    run_n = 1'b1;
    wt(DEB + 10);
    chk("all off", {main_on, aux_on}, 2'b00);
    run_n = 1'b0;
    wt(DEB + 10);
    chk("lockout", aux_on, 1'b0);
    n = 2 * DEB + 20;
    while (aux_on !== 1'b1 && n < LCK + 50) begin
      wt(1);
      n++;
    end
    chk("lockout len", n >= LCK && n <= LCK + 4, 1'b1);
    hoff_n = 1'b0;
    wt(DEB + 10);
    chk("aux only", {main_on, aux_on}, 2'b01);
    hoff_n = 1'b1;
    wt(DEB + 10);
    chk("rearm held", main_on, 1'b0);
    wt(LCK);
    chk("rearm", main_on, 1'b1);
    $display("control tests done");
    chk("queue left", 8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule // supply_control_pin_logic_bench

// ==== hw/spc_defines.vh ====
/*
 * Shared constants for the supply control pin logic: bus address base,
 * read command codes and timing figures.
 * Assumes the includer uses the constants as plain integers or sized literals.
 */
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// Clock rate in kHz, so that a time in ms times this rate gives cycles
`define SPC_CLK_KHZ 250000

// Debounce of the two output-control inputs, in ms
`define SPC_CTRL_DEB_MS 5
// Least spacing between output-enable transitions, in ms
`define SPC_LOCK_MS 5
// Debounce of the slot-address inputs, in ms
`define SPC_ADDR_DEB_MS 5

// Slot address base; the low two bits come from the slot pins
`define SPC_ADDR_BASE 7'h20

// Read command codes
`define SPC_CMD_TEMP_MAX 8'h21
`define SPC_CMD_TEMP_BOTH 8'h92
// Reply byte for commands that have no data here
`define SPC_REPLY_NONE 8'hff

// Reset values
`define SPC_CMD_RESET 8'h00

`endif

// ==== hw/spc_i2c_target.v ====
/*
 * One I2C target port answering the temperature read commands.
 * Assumes scl and sda arrive from pins asynchronously, that the pins are
 * open drain with pull-ups outside, and that own_addr is steady once
 * addr_valid is high.
 */
`include "spc_defines.vh"

module spc_i2c_target (
  input wire clk,
  input wire rst_n,
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  input wire [6:0] own_addr,
  input wire addr_valid,
  input wire [7:0] temp_hi,
  input wire [7:0] temp_a,
  input wire [7:0] temp_b
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX = 5'h02;
  localparam [4:0] ST_ACK = 5'h04;
  localparam [4:0] ST_TX = 5'h08;
  localparam [4:0] ST_MACK = 5'h10;

  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg scl_prev_reg;
  reg sda_prev_reg;
  reg [4:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] rx_reg;
  reg [7:0] tx_reg;
  reg [7:0] cmd_reg;
  reg [1:0] byte_idx_reg;
  reg is_addr_reg;
  reg rd_reg;
  reg mnack_reg;
  reg [7:0] tx_data;

  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire start_seen = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire stop_seen = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // Reply byte for the current position in the read
  always @* begin
    tx_data = `SPC_REPLY_NONE;
    if (cmd_reg == `SPC_CMD_TEMP_MAX && byte_idx_reg == 2'd0)
      tx_data = temp_hi; // R10
    else if (cmd_reg == `SPC_CMD_TEMP_BOTH && byte_idx_reg == 2'd0)
      tx_data = temp_a; // R11
    else if (cmd_reg == `SPC_CMD_TEMP_BOTH && byte_idx_reg == 2'd1)
      tx_data = temp_b; // R11
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      cmd_reg <= `SPC_CMD_RESET;
      byte_idx_reg <= 2'd0;
      is_addr_reg <= 1'b0;
      rd_reg <= 1'b0;
      mnack_reg <= 1'b0;
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      if (start_seen) begin
        // A repeated start keeps the command for the read that follows
        state_reg <= addr_valid ? ST_RX : ST_IDLE;
        is_addr_reg <= 1'b1;
        bit_cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == ST_RX) begin
          rx_reg <= {rx_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (state_reg == ST_MACK)
          mnack_reg <= sda_s;
      end else if (scl_fall) begin
        case (state_reg)
          ST_RX: begin
            if (bit_cnt_reg == 4'h8) begin
              if (is_addr_reg) begin
                if (rx_reg[7:1] == own_addr) begin // R7
                  rd_reg <= rx_reg[0];
                  sda_oe <= 1'b1;
                  state_reg <= ST_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                cmd_reg <= rx_reg;
                byte_idx_reg <= 2'd0;
                sda_oe <= 1'b1;
                state_reg <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            bit_cnt_reg <= 4'h0;
            if (is_addr_reg && rd_reg) begin
              sda_oe <= ~tx_data[7];
              tx_reg <= {tx_data[6:0], 1'b0};
              byte_idx_reg <= byte_idx_reg + 2'd1;
              bit_cnt_reg <= 4'h1;
              state_reg <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              state_reg <= ST_RX;
            end
            is_addr_reg <= 1'b0;
          end
          ST_TX: begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe <= 1'b0;
              state_reg <= ST_MACK;
            end else begin
              sda_oe <= ~tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          ST_MACK: begin
            if (mnack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              sda_oe <= ~tx_data[7];
              tx_reg <= {tx_data[6:0], 1'b0};
              byte_idx_reg <= byte_idx_reg + 2'd1;
              bit_cnt_reg <= 4'h1;
              state_reg <= ST_TX;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // spc_i2c_target

// ==== hw/spc_top.v ====
/*
 * Control and status pin logic of a backplane supply: output-control
 * decode with debounce and lockout, slot address capture, two open-drain
 * status lines and two identical I2C target ports.
 * Assumes every pin input is asynchronous to clk, supply_ready and
 * out_of_spec come from the power stage, and temperatures are steady words.
 */
`include "spc_defines.vh"

// Operation
// [R1] Primary control low with hold-off high enables all rails, both low enables aux only, primary high disables all.
// [R2] Both output-control inputs are debounced before the decode acts on them.
// [R3] Successive output-enable transitions are spaced by at least the lockout time; early requests wait.
// [R4] The active-low slot pins give bus address 20h to 23h, an open pin reading as one.
// [R5] Both slot pins are debounced before the address is formed.
// [R6] The slot address is latched once after power-up and held until the next power cycle.
// [R7] Two I2C ports answer at the same latched address with identical behaviour.
// [R8] The fault line is open drain, follows the hold line during power-up, and later pulls low on out-of-spec.
// [R9] The hold line is pulled low during power-up and released once the supply is ready.
// [R10] Command 21h returns the higher of the two sensor temperatures.
// [R11] Command 92h returns both sensor temperatures.
// [R12] The system manager uses the slot address and may reach the same functions on either port.
module spc_top #(
  parameter integer CTRL_DEB = `SPC_CTRL_DEB_MS * `SPC_CLK_KHZ,
  parameter integer ADDR_DEB = `SPC_ADDR_DEB_MS * `SPC_CLK_KHZ,
  parameter integer LOCK_CYC = `SPC_LOCK_MS * `SPC_CLK_KHZ,
  parameter integer CW = 21
) (
  input wire clk,
  input wire rst_n,
  input wire run_req_n,
  input wire hold_off_n,
  input wire slot_id_bit0_n,
  input wire slot_id_bit1_n,
  input wire supply_ready,
  input wire out_of_spec,
  input wire [7:0] temp_a,
  input wire [7:0] temp_b,
  output reg main_on,
  output reg aux_on,
  input wire system_hold_n_i,
  output reg system_hold_n_o,
  output reg system_hold_n_oe,
  input wire fault_n_i,
  output reg fault_n_o,
  output reg fault_n_oe,
  input wire i2c0_scl_i,
  output wire i2c0_scl_o,
  output wire i2c0_scl_oe,
  input wire i2c0_sda_i,
  output wire i2c0_sda_o,
  output wire i2c0_sda_oe,
  input wire i2c1_scl_i,
  output wire i2c1_scl_o,
  output wire i2c1_scl_oe,
  input wire i2c1_sda_i,
  output wire i2c1_sda_o,
  output wire i2c1_sda_oe
);
  localparam [CW-1:0] CTRL_LIM = CTRL_DEB[CW-1:0];
  localparam [CW-1:0] ADDR_LIM = ADDR_DEB[CW-1:0];
  localparam [CW-1:0] LOCK_LIM = LOCK_CYC[CW-1:0];
  // Capture eight cycles after one full address debounce so the filter has settled
  localparam [CW-1:0] CAP_AT = ADDR_LIM + 4'h8;

  // Index 0/1: output-control inputs, 2/3: slot bits
  wire [3:0] raw_in = {slot_id_bit1_n, slot_id_bit0_n, hold_off_n, run_req_n};
  wire [3:0] filt;

  reg [1:0] rdy_sync_reg;
  reg [1:0] oos_sync_reg;
  reg [CW-1:0] pwr_cnt_reg;
  reg addr_locked_reg;
  reg [6:0] slot_addr_reg;
  reg pwr_done_reg;
  reg [CW-1:0] lock_cnt_reg;
  reg [7:0] temp_hi_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_deb
      reg [1:0] sync_reg;
      reg stable_reg;
      reg [CW-1:0] cnt_reg;
      wire [CW-1:0] lim = (gi < 2) ? CTRL_LIM : ADDR_LIM;
      // Pull-ups make an open pin read high, so the filter starts high
      always @(posedge clk) begin
        if (!rst_n) begin
          sync_reg <= 2'b11;
          stable_reg <= 1'b1;
          cnt_reg <= {CW{1'b0}};
        end else begin
          sync_reg <= {sync_reg[0], raw_in[gi]};
          if (sync_reg[1] == stable_reg) begin
            cnt_reg <= {CW{1'b0}};
          end else if (cnt_reg >= lim - 1'b1) begin // R2 R5
            stable_reg <= sync_reg[1];
            cnt_reg <= {CW{1'b0}};
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      end
      assign filt[gi] = stable_reg;
    end
  endgenerate

  wire en_f = filt[0];
  wire inh_f = filt[1];
  // Decoded only from filtered levels; a glitch never reaches the rails
  reg want_aux;
  reg want_main;

  // Truth table of the two filtered active-low controls
  always @* begin
    want_aux = 1'b0;
    want_main = 1'b0;
    if (pwr_done_reg) begin
      case ({en_f, inh_f})
        2'b01: begin
          want_aux = 1'b1; // R1
          want_main = 1'b1; // R1
        end
        2'b00: begin
          want_aux = 1'b1; // R1
        end
        default: begin
          want_aux = 1'b0;
        end
      endcase
    end
  end

  wire lock_done = (lock_cnt_reg == {CW{1'b0}});
  wire new_start = lock_done & ((want_aux & ~aux_on) | (want_main & ~main_on));

  always @(posedge clk) begin
    if (!rst_n) begin
      rdy_sync_reg <= 2'b00;
      oos_sync_reg <= 2'b00;
      pwr_cnt_reg <= {CW{1'b0}};
      addr_locked_reg <= 1'b0;
      slot_addr_reg <= `SPC_ADDR_BASE;
      pwr_done_reg <= 1'b0;
      temp_hi_reg <= 8'h00;
    end else begin
      rdy_sync_reg <= {rdy_sync_reg[0], supply_ready};
      oos_sync_reg <= {oos_sync_reg[0], out_of_spec};
      temp_hi_reg <= (temp_a > temp_b) ? temp_a : temp_b; // R10
      if (!addr_locked_reg) begin
        if (pwr_cnt_reg >= CAP_AT) begin
          // Latched once; later pin changes wait for the next power cycle
          addr_locked_reg <= 1'b1; // R6
          slot_addr_reg <= `SPC_ADDR_BASE | {5'h00, ~filt[3], ~filt[2]}; // R4
        end else begin
          pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
        end
      end
      if (addr_locked_reg && rdy_sync_reg[1])
        pwr_done_reg <= 1'b1; // R9
    end
  end

  // Disabling is immediate; only turning a rail on is held by the lockout
  always @(posedge clk) begin
    if (!rst_n) begin
      main_on <= 1'b0;
      aux_on <= 1'b0;
      lock_cnt_reg <= {CW{1'b0}};
    end else begin
      // A rail that is already on stays on while the lockout runs
      if (!want_aux)
        aux_on <= 1'b0;
      else if (lock_done)
        aux_on <= 1'b1; // R3
      if (!want_main)
        main_on <= 1'b0;
      else if (lock_done)
        main_on <= 1'b1; // R3
      if (new_start)
        lock_cnt_reg <= LOCK_LIM; // R3
      else if (!lock_done)
        lock_cnt_reg <= lock_cnt_reg - 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      system_hold_n_o <= 1'b0;
      system_hold_n_oe <= 1'b1;
      fault_n_o <= 1'b0;
      fault_n_oe <= 1'b1;
    end else begin
      system_hold_n_o <= 1'b0;
      fault_n_o <= 1'b0;
      system_hold_n_oe <= ~pwr_done_reg; // R9
      // While powering up the fault line mirrors the hold line
      fault_n_oe <= pwr_done_reg ? oos_sync_reg[1] : 1'b1; // R8
    end
  end

  // Both ports see the same address and data, so they answer alike
  spc_i2c_target u_port0 ( // R7
    .clk(clk),
    .rst_n(rst_n),
    .scl_i(i2c0_scl_i),
    .scl_o(i2c0_scl_o),
    .scl_oe(i2c0_scl_oe),
    .sda_i(i2c0_sda_i),
    .sda_o(i2c0_sda_o),
    .sda_oe(i2c0_sda_oe),
    .own_addr(slot_addr_reg),
    .addr_valid(addr_locked_reg),
    .temp_hi(temp_hi_reg),
    .temp_a(temp_a),
    .temp_b(temp_b)
  );

  spc_i2c_target u_port1 ( // R7
    .clk(clk),
    .rst_n(rst_n),
    .scl_i(i2c1_scl_i),
    .scl_o(i2c1_scl_o),
    .scl_oe(i2c1_scl_oe),
    .sda_i(i2c1_sda_i),
    .sda_o(i2c1_sda_o),
    .sda_oe(i2c1_sda_oe),
    .own_addr(slot_addr_reg),
    .addr_valid(addr_locked_reg),
    .temp_hi(temp_hi_reg),
    .temp_a(temp_a),
    .temp_b(temp_b)
  );
endmodule // spc_top
